// ===== core/ldrr_pkg.sv
// Package: constants and carrier types for logical device resource routing
package ldrr_pkg;
  localparam int NUM_DEV = 5;
  localparam logic [2:0] DEV_DISK = 3'h0;
  localparam logic [2:0] DEV_PRN = 3'h1;
  localparam logic [2:0] DEV_SER1 = 3'h2;
  localparam logic [2:0] DEV_SER2 = 3'h3;
  localparam logic [2:0] DEV_KBD = 3'h4;
  localparam logic [7:0] LDN_DISK = 8'h00;
  localparam logic [7:0] LDN_PRN = 8'h03;
  localparam logic [7:0] LDN_SER1 = 8'h04;
  localparam logic [7:0] LDN_SER2 = 8'h05;
  localparam logic [7:0] LDN_KBD = 8'h07;
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_BASE0_HI = 8'h60;
  localparam logic [7:0] IDX_BASE0_LO = 8'h61;
  localparam logic [7:0] IDX_BASE1_HI = 8'h62;
  localparam logic [7:0] IDX_BASE1_LO = 8'h63;
  localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
  localparam logic [7:0] IDX_DMA_SEL = 8'h74;
  localparam logic [7:0] IRQ_SEL_RST = 8'h00;
  localparam logic [7:0] DMA_SEL_RST = 8'h04;
  localparam logic [7:0] BASE_RST = 8'h00;
  localparam logic [11:0] BASE_MIN = 12'h100;
  localparam logic [11:0] BASE_MAX_4 = 12'hffc;
  localparam logic [11:0] BASE_MAX_8 = 12'hff8;
  localparam logic [11:0] OFS_EPP_ADDR = 12'h003;
  localparam logic [11:0] OFS_EPP_DATA = 12'h004;
  localparam logic [11:0] OFS_EXT_FIFO = 12'h400;
  localparam logic [11:0] OFS_EXT_CFGB = 12'h401;
  localparam logic [11:0] OFS_EXT_CTRL = 12'h402;
  localparam logic [11:0] KBD_DATA_ADDR = 12'h060;
  localparam logic [11:0] KBD_CMD_ADDR = 12'h064;
  localparam int DISK_GATE_BIT = 3;
  localparam int PRN_IRQ_GATE_BIT = 4;
  localparam int EXT_SVC_BIT = 2;
  localparam int EXT_DMA_BIT = 3;
  localparam int UART_AUX2_BIT = 3;
  localparam logic [2:0] EXT_MODE_FIFO = 3'h2;
  localparam logic [2:0] EXT_MODE_ECP = 3'h3;
  localparam logic [2:0] EXT_MODE_EPP = 3'h4;
  localparam logic [2:0] EXT_MODE_TEST = 3'h6;
  localparam int NUM_IRQ = 16;
  localparam int NUM_DMA = 4;

  // Per-device gate bits reported by each function's own registers
  typedef struct packed {
    logic disk_dma_irq_gate;
    logic prn_irq_gate;
    logic [2:0] ext_mode;
    logic ext_service_intr;
    logic ext_dma_enable;
    logic [3:0] uart1_int_enable;
    logic uart1_aux2;
    logic [3:0] uart2_int_enable;
    logic uart2_aux2;
  } dev_gate_t;

  // Decoded host access for one device
  typedef struct packed {
    logic [2:0] dev;
    logic [11:0] offset;
    logic hit;
  } io_hit_t;
endpackage : ldrr_pkg

// ===== core/base_window.sv
// One relocatable base window: range check and offset decode
`timescale 1ns/1ps
module base_window
  import ldrr_pkg::*;
#(
  parameter logic [11:0] ALIGN_MASK = 12'h007,
  parameter logic [11:0] MAX_BASE = 12'hff8,
  parameter logic [11:0] SPAN = 12'h008
) (
  input wire logic [15:0] i_base,
  input wire logic i_active,
  input wire logic [15:0] i_addr,
  output logic o_valid,
  output logic o_hit,
  output logic [11:0] o_offset
);
  wire [11:0] base12 = i_base[11:0];
  wire [11:0] addr12 = i_addr[11:0];
  wire [11:0] diff = addr12 - base12;
  // Base outside its range or misaligned makes the device deaf
  assign o_valid = (i_base[15:12] == 4'h0) && (base12 >= BASE_MIN) && (base12 <= MAX_BASE)
                   && ((base12 & ALIGN_MASK) == 12'h000);
  // Only A11..A0 take part in the match
  assign o_hit = i_active && o_valid && (addr12 >= base12) && (diff < SPAN);
  assign o_offset = diff;
endmodule : base_window

// ===== core/logical_device_resource_routing.sv
// Logical device configuration registers, address decode and IRQ/DMA routing
`timescale 1ns/1ps
module logical_device_resource_routing
  import ldrr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Configuration port: index/data access, accepted at any time with no configuration-state gating
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic i_cfg_is_index,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  // Host I/O address and strobes for the functional registers
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  output logic [NUM_DEV-1:0] o_dev_sel_rd,
  output logic [NUM_DEV-1:0] o_dev_sel_wr,
  output logic [11:0] o_dev_offset,
  output logic o_epp_addr_sel,
  output logic o_epp_data_sel,
  output logic [1:0] o_epp_lane,
  output logic o_ext_fifo_sel,
  output logic o_ext_cfgb_sel,
  output logic o_ext_ctrl_sel,
  // Raw requests and gate bits from the functions
  input wire logic [NUM_DEV-1:0] i_dev_irq,
  input wire logic [NUM_DEV-1:0] i_dev_drq,
  input wire dev_gate_t i_gates,
  output logic [NUM_DEV-1:0] o_dev_dack_en,
  // Tri-state pins
  output logic [NUM_IRQ-1:0] o_irq,
  output logic [NUM_IRQ-1:0] o_irq_oe,
  output logic [NUM_DMA-1:0] o_dma_request_pin,
  output logic [NUM_DMA-1:0] o_dma_request_pin_oe
);
  logic [7:0] index_q;
  logic [7:0] ldn_q;
  logic [NUM_DEV-1:0] act_q;
  logic [7:0] base_hi_q [NUM_DEV];
  logic [7:0] base_lo_q [NUM_DEV];
  logic [7:0] base2_hi_q [NUM_DEV];
  logic [7:0] base2_lo_q [NUM_DEV];
  logic [7:0] irq_level_select_q [NUM_DEV];
  logic [7:0] dma_channel_select_q [NUM_DEV];
  logic [NUM_IRQ-1:0] irq_q;
  logic [NUM_IRQ-1:0] irq_oe_q;
  logic [NUM_DMA-1:0] drq_q;
  logic [NUM_DMA-1:0] drq_oe_q;

  // Logical device number to internal slot
  wire ldn_known = (ldn_q == LDN_DISK) || (ldn_q == LDN_PRN) || (ldn_q == LDN_SER1)
                   || (ldn_q == LDN_SER2) || (ldn_q == LDN_KBD);
  wire [2:0] slot = (ldn_q == LDN_DISK) ? DEV_DISK :
                    (ldn_q == LDN_PRN) ? DEV_PRN :
                    (ldn_q == LDN_SER1) ? DEV_SER1 :
                    (ldn_q == LDN_SER2) ? DEV_SER2 : DEV_KBD;
  wire has_base = ldn_known && (slot != DEV_KBD);
  wire has_base2 = ldn_known && (slot == DEV_SER2);
  wire has_dma = ldn_known && ((slot == DEV_DISK) || (slot == DEV_PRN) || (slot == DEV_SER2));
  wire data_wr = i_cfg_wr && !i_cfg_is_index;
  wire wr_ldn = data_wr && (index_q == IDX_LDN);
  wire wr_dev = data_wr && ldn_known;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      index_q <= 8'h00;
      ldn_q <= 8'h00;
    end else begin
      if (i_cfg_wr && i_cfg_is_index) begin
        index_q <= i_cfg_wdata;
      end
      if (wr_ldn) begin
        ldn_q <= i_cfg_wdata;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_DEV; g++) begin : g_dev_regs
      wire sel = wr_dev && (slot == 3'(g));
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          act_q[g] <= 1'b0;
          base_hi_q[g] <= BASE_RST;
          base_lo_q[g] <= BASE_RST;
          base2_hi_q[g] <= BASE_RST;
          base2_lo_q[g] <= BASE_RST;
          irq_level_select_q[g] <= IRQ_SEL_RST;
          dma_channel_select_q[g] <= DMA_SEL_RST;
        end else if (sel) begin
          if (index_q == IDX_ACT) begin
            act_q[g] <= i_cfg_wdata[0];
          end
          if (has_base && index_q == IDX_BASE0_HI) begin
            base_hi_q[g] <= i_cfg_wdata;
          end
          if (has_base && index_q == IDX_BASE0_LO) begin
            base_lo_q[g] <= i_cfg_wdata;
          end
          if (has_base2 && index_q == IDX_BASE1_HI) begin
            base2_hi_q[g] <= i_cfg_wdata;
          end
          if (has_base2 && index_q == IDX_BASE1_LO) begin
            base2_lo_q[g] <= i_cfg_wdata;
          end
          if (index_q == IDX_IRQ_SEL) begin
            irq_level_select_q[g] <= {4'h0, i_cfg_wdata[3:0]};
          end
          if (has_dma && index_q == IDX_DMA_SEL) begin
            dma_channel_select_q[g] <= {5'h00, i_cfg_wdata[2:0]};
          end
        end
      end
    end
  endgenerate

  // Configuration readback; unused indexes read zero
  logic [7:0] cfg_rd_d;
  always_comb begin
    cfg_rd_d = 8'h00;
    if (i_cfg_is_index) begin
      cfg_rd_d = index_q;
    end else if (index_q == IDX_LDN) begin
      cfg_rd_d = ldn_q;
    end else if (ldn_known) begin
      unique case (index_q)
        IDX_ACT: cfg_rd_d = {7'h00, act_q[slot]};
        IDX_BASE0_HI: cfg_rd_d = has_base ? base_hi_q[slot] : 8'h00;
        IDX_BASE0_LO: cfg_rd_d = has_base ? base_lo_q[slot] : 8'h00;
        IDX_BASE1_HI: cfg_rd_d = has_base2 ? base2_hi_q[slot] : 8'h00;
        IDX_BASE1_LO: cfg_rd_d = has_base2 ? base2_lo_q[slot] : 8'h00;
        IDX_IRQ_SEL: cfg_rd_d = irq_level_select_q[slot];
        IDX_DMA_SEL: cfg_rd_d = has_dma ? dma_channel_select_q[slot] : 8'h00;
        default: cfg_rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_cfg_rdata <= 8'h00;
    end else if (i_cfg_rd) begin
      o_cfg_rdata <= cfg_rd_d;
    end
  end

  // Address windows; printer uses 8-byte alignment only when EPP is wanted
  wire prn_epp = (i_gates.ext_mode == EXT_MODE_EPP);
  logic [NUM_DEV-1:0] win_hit;
  logic [11:0] win_ofs [NUM_DEV];
  logic prn_ext_hit;
  logic [11:0] prn_ext_ofs;
  logic ser2_hit2;
  logic [11:0] ser2_ofs2;
  logic prn_valid4;
  logic prn_valid8;
  logic prn_hit4;
  logic prn_hit8;
  logic [11:0] prn_ofs4;
  logic [11:0] prn_ofs8;

  base_window #(.ALIGN_MASK(12'h007), .MAX_BASE(BASE_MAX_8), .SPAN(12'h008)) u_disk_win (
    .i_base({base_hi_q[DEV_DISK], base_lo_q[DEV_DISK]}), .i_active(act_q[DEV_DISK]), .i_addr(i_io_addr),
    .o_valid(), .o_hit(win_hit[DEV_DISK]), .o_offset(win_ofs[DEV_DISK]));
  base_window #(.ALIGN_MASK(12'h003), .MAX_BASE(BASE_MAX_4), .SPAN(12'h004)) u_prn_win4 (
    .i_base({base_hi_q[DEV_PRN], base_lo_q[DEV_PRN]}), .i_active(act_q[DEV_PRN]), .i_addr(i_io_addr),
    .o_valid(prn_valid4), .o_hit(prn_hit4), .o_offset(prn_ofs4));
  base_window #(.ALIGN_MASK(12'h007), .MAX_BASE(BASE_MAX_8), .SPAN(12'h008)) u_prn_win8 (
    .i_base({base_hi_q[DEV_PRN], base_lo_q[DEV_PRN]}), .i_active(act_q[DEV_PRN]), .i_addr(i_io_addr),
    .o_valid(prn_valid8), .o_hit(prn_hit8), .o_offset(prn_ofs8));
  base_window #(.ALIGN_MASK(12'h003), .MAX_BASE(BASE_MAX_4), .SPAN(12'h003)) u_prn_ext (
    .i_base({base_hi_q[DEV_PRN], base_lo_q[DEV_PRN]} + 16'h0400), .i_active(act_q[DEV_PRN] && prn_valid4),
    .i_addr(i_io_addr), .o_valid(), .o_hit(prn_ext_hit), .o_offset(prn_ext_ofs));
  base_window #(.ALIGN_MASK(12'h007), .MAX_BASE(BASE_MAX_8), .SPAN(12'h008)) u_ser1_win (
    .i_base({base_hi_q[DEV_SER1], base_lo_q[DEV_SER1]}), .i_active(act_q[DEV_SER1]), .i_addr(i_io_addr),
    .o_valid(), .o_hit(win_hit[DEV_SER1]), .o_offset(win_ofs[DEV_SER1]));
  base_window #(.ALIGN_MASK(12'h007), .MAX_BASE(BASE_MAX_8), .SPAN(12'h008)) u_ser2_win (
    .i_base({base_hi_q[DEV_SER2], base_lo_q[DEV_SER2]}), .i_active(act_q[DEV_SER2]), .i_addr(i_io_addr),
    .o_valid(), .o_hit(win_hit[DEV_SER2]), .o_offset(win_ofs[DEV_SER2]));
  base_window #(.ALIGN_MASK(12'h007), .MAX_BASE(BASE_MAX_8), .SPAN(12'h008)) u_ser2_win2 (
    .i_base({base2_hi_q[DEV_SER2], base2_lo_q[DEV_SER2]}), .i_active(act_q[DEV_SER2]), .i_addr(i_io_addr),
    .o_valid(), .o_hit(ser2_hit2), .o_offset(ser2_ofs2));

  // EPP window only on an 8-byte aligned base, else 4-byte window
  wire prn_main_hit = (prn_epp && prn_valid8) ? prn_hit8 : prn_hit4;
  wire [11:0] prn_main_ofs = (prn_epp && prn_valid8) ? prn_ofs8 : prn_ofs4;
  assign win_hit[DEV_PRN] = prn_main_hit || prn_ext_hit;
  assign win_ofs[DEV_PRN] = prn_ext_hit ? (prn_ext_ofs + OFS_EXT_FIFO) : prn_main_ofs;
  wire kbd_data = (i_io_addr[11:0] == KBD_DATA_ADDR);
  wire kbd_cmd = (i_io_addr[11:0] == KBD_CMD_ADDR);
  assign win_hit[DEV_KBD] = act_q[DEV_KBD] && (kbd_data || kbd_cmd);
  assign win_ofs[DEV_KBD] = kbd_cmd ? 12'h004 : 12'h000;
  wire [NUM_DEV-1:0] any_hit = win_hit | {1'b0, ser2_hit2, 3'h0};

  logic [11:0] ofs_d;
  always_comb begin
    ofs_d = 12'h000;
    for (int i = NUM_DEV - 1; i >= 0; i--) begin
      if (win_hit[i]) begin
        ofs_d = win_ofs[i];
      end
    end
    if (ser2_hit2 && !win_hit[DEV_SER2]) begin
      ofs_d = ser2_ofs2;
    end
  end

  assign o_dev_sel_rd = i_io_rd ? any_hit : '0;
  assign o_dev_sel_wr = i_io_wr ? any_hit : '0;
  assign o_dev_offset = ofs_d;
  wire prn_cycle = (i_io_rd || i_io_wr) && prn_main_hit && prn_epp && prn_valid8;
  assign o_epp_addr_sel = prn_cycle && (prn_main_ofs == OFS_EPP_ADDR);
  assign o_epp_data_sel = prn_cycle && (prn_main_ofs[2] == OFS_EPP_DATA[2]);
  assign o_epp_lane = prn_main_ofs[1:0];
  wire ext_cycle = (i_io_rd || i_io_wr) && prn_ext_hit;
  assign o_ext_fifo_sel = ext_cycle && (win_ofs[DEV_PRN] == OFS_EXT_FIFO);
  assign o_ext_cfgb_sel = ext_cycle && (win_ofs[DEV_PRN] == OFS_EXT_CFGB);
  assign o_ext_ctrl_sel = ext_cycle && (win_ofs[DEV_PRN] == OFS_EXT_CTRL);

  // Device-specific interrupt gates
  wire ecp_mode = (i_gates.ext_mode == EXT_MODE_FIFO) || (i_gates.ext_mode == EXT_MODE_ECP)
                  || (i_gates.ext_mode == EXT_MODE_TEST);
  logic [NUM_DEV-1:0] irq_gate;
  logic [NUM_DEV-1:0] drq_gate;
  assign irq_gate[DEV_DISK] = i_gates.disk_dma_irq_gate;
  // Control port gate always applies; ECP-class modes also need the service bit clear
  assign irq_gate[DEV_PRN] = i_gates.prn_irq_gate && !(ecp_mode && i_gates.ext_service_intr);
  assign irq_gate[DEV_SER1] = (|i_gates.uart1_int_enable) && i_gates.uart1_aux2;
  assign irq_gate[DEV_SER2] = (|i_gates.uart2_int_enable) && i_gates.uart2_aux2;
  assign irq_gate[DEV_KBD] = 1'b1;
  assign drq_gate[DEV_DISK] = i_gates.disk_dma_irq_gate;
  assign drq_gate[DEV_PRN] = ecp_mode ? i_gates.ext_dma_enable : 1'b1;
  assign drq_gate[DEV_SER1] = 1'b0;
  assign drq_gate[DEV_SER2] = 1'b1;
  assign drq_gate[DEV_KBD] = 1'b0;

  logic [NUM_DEV-1:0] irq_on;
  logic [NUM_DEV-1:0] drq_on;
  generate
    for (g = 0; g < NUM_DEV; g++) begin : g_route_en
      assign irq_on[g] = act_q[g] && (irq_level_select_q[g][3:0] != 4'h0) && irq_gate[g];
      assign drq_on[g] = act_q[g] && (dma_channel_select_q[g][2:0] >= 3'h1)
                         && (dma_channel_select_q[g][2:0] <= 3'h3) && drq_gate[g];
    end
  endgenerate
  assign o_dev_dack_en = drq_on;

  // Line n collects every enabled device routed to n; unused lines float
  logic [NUM_IRQ-1:0] irq_d;
  logic [NUM_IRQ-1:0] irq_oe_d;
  logic [NUM_DMA-1:0] drq_d;
  logic [NUM_DMA-1:0] drq_oe_d;
  always_comb begin
    irq_d = '0;
    irq_oe_d = '0;
    drq_d = '0;
    drq_oe_d = '0;
    for (int i = 0; i < NUM_DEV; i++) begin
      if (irq_on[i]) begin
        irq_oe_d[irq_level_select_q[i][3:0]] = 1'b1;
        irq_d[irq_level_select_q[i][3:0]] = irq_d[irq_level_select_q[i][3:0]] | i_dev_irq[i];
      end
      if (drq_on[i]) begin
        drq_oe_d[dma_channel_select_q[i][1:0]] = 1'b1;
        drq_d[dma_channel_select_q[i][1:0]] = drq_d[dma_channel_select_q[i][1:0]] | i_dev_drq[i];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      irq_q <= '0;
      irq_oe_q <= '0;
      drq_q <= '0;
      drq_oe_q <= '0;
    end else begin
      irq_q <= irq_d;
      irq_oe_q <= irq_oe_d;
      drq_q <= drq_d;
      drq_oe_q <= drq_oe_d;
    end
  end
  assign o_irq = irq_q;
  assign o_irq_oe = irq_oe_q;
  assign o_dma_request_pin = drq_q;
  assign o_dma_request_pin_oe = drq_oe_q;

  a_irq_zero_float: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !irq_oe_q[0]) else $error("irq line 0 driven");
  a_dma_zero_float: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !drq_oe_q[0]) else $error("dma line 0 driven");
  a_disk_irq_gate: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (act_q[DEV_DISK] && irq_level_select_q[DEV_DISK][3:0] != 4'h0 && !i_gates.disk_dma_irq_gate
     && irq_level_select_q[DEV_DISK] == $past(irq_level_select_q[DEV_DISK])
     && (irq_level_select_q[DEV_DISK] != irq_level_select_q[DEV_PRN] || !irq_on[DEV_PRN])
     && (irq_level_select_q[DEV_DISK] != irq_level_select_q[DEV_SER1] || !irq_on[DEV_SER1])
     && (irq_level_select_q[DEV_DISK] != irq_level_select_q[DEV_SER2] || !irq_on[DEV_SER2])
     && (irq_level_select_q[DEV_DISK] != irq_level_select_q[DEV_KBD] || !irq_on[DEV_KBD]))
    |=> !irq_oe_q[$past(irq_level_select_q[DEV_DISK][3:0])])
    else $error("disk irq driven without gate");
  a_irq_route_one: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    irq_on[DEV_SER1] |=> irq_oe_q[$past(irq_level_select_q[DEV_SER1][3:0])]) else $error("serial irq not routed");
  a_irq_follow: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (irq_on[DEV_SER1] && i_dev_irq[DEV_SER1]) |=> irq_q[$past(irq_level_select_q[DEV_SER1][3:0])])
    else $error("serial irq level lost");
  a_dma_route_one: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    drq_on[DEV_PRN] |=> drq_oe_q[$past(dma_channel_select_q[DEV_PRN][1:0])]) else $error("printer dma not routed");
  a_dma_reset_val: assert property (@(posedge i_clk_sys)
    i_srst |=> (dma_channel_select_q[DEV_DISK] == DMA_SEL_RST)) else $error("dma select reset wrong");
  a_kbd_fixed_addr: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_io_rd && act_q[DEV_KBD] && i_io_addr[11:0] == KBD_CMD_ADDR) |-> o_dev_sel_rd[DEV_KBD])
    else $error("keyboard not decoded");
  a_ignore_high_bits: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (o_dev_sel_rd[DEV_DISK] || o_dev_sel_wr[DEV_DISK])
    |-> ((i_io_addr[11:0] - {base_hi_q[DEV_DISK][3:0], base_lo_q[DEV_DISK]}) < 12'h008))
    else $error("disk decode outside window");
endmodule : logical_device_resource_routing

// ===== verif/isa_host_model.sv
// Host-side model: resolves the tri-state request lines and counts interrupt edges
`timescale 1ns/1ps
module isa_host_model
  import ldrr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [NUM_IRQ-1:0] i_irq,
  input wire logic [NUM_IRQ-1:0] i_irq_oe,
  input wire logic [NUM_DMA-1:0] i_drq,
  input wire logic [NUM_DMA-1:0] i_drq_oe,
  output logic [NUM_IRQ-1:0] o_irq_line,
  output logic [NUM_DMA-1:0] o_drq_line,
  output logic [7:0] o_irq_edges
);
  logic [NUM_IRQ-1:0] irq_q = '0;
  logic [7:0] edges_q = 8'h00;
  // Released lines fall to their pull-down level
  assign o_irq_line = i_irq & i_irq_oe;
  assign o_drq_line = i_drq & i_drq_oe;
  assign o_irq_edges = edges_q;
  always @(posedge i_clk_sys) begin
    irq_q <= o_irq_line;
    edges_q <= edges_q + 8'($countones(o_irq_line & ~irq_q));
  end
endmodule : isa_host_model

// ===== verif/test_logical_device_resource_routing.sv
// Self-checking bench for configuration, host decode and request routing
`timescale 1ns/1ps
module test_logical_device_resource_routing;
  import ldrr_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  logic i_cfg_wr = 1'b0, i_cfg_rd = 1'b0, i_cfg_is_index = 1'b0, i_io_rd = 1'b0, i_io_wr = 1'b0;
  logic [7:0] i_cfg_wdata = 8'h00;
  logic [7:0] o_cfg_rdata, irq_edges;
  logic [15:0] i_io_addr = 16'h0000;
  logic [NUM_DEV-1:0] i_dev_irq = '0, i_dev_drq = '0, o_dev_sel_rd, o_dev_sel_wr, o_dev_dack_en;
  dev_gate_t i_gates = '0;
  dev_gate_t g = '0;
  logic [11:0] o_dev_offset;
  logic o_epp_addr_sel, o_epp_data_sel, o_ext_fifo_sel, o_ext_cfgb_sel, o_ext_ctrl_sel;
  logic [1:0] o_epp_lane;
  logic [NUM_IRQ-1:0] o_irq, o_irq_oe, irq_line;
  logic [NUM_DMA-1:0] o_dma_request_pin, o_dma_request_pin_oe, drq_line;
  int fails = 0, check_count = 0, cyc = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  logical_device_resource_routing i_logical_device_resource_routing (
    .i_clk_sys, .i_srst, .i_cfg_wr, .i_cfg_rd, .i_cfg_is_index, .i_cfg_wdata, .o_cfg_rdata,
    .i_io_addr, .i_io_rd, .i_io_wr, .o_dev_sel_rd, .o_dev_sel_wr, .o_dev_offset,
    .o_epp_addr_sel, .o_epp_data_sel, .o_epp_lane, .o_ext_fifo_sel, .o_ext_cfgb_sel,
    .o_ext_ctrl_sel, .i_dev_irq, .i_dev_drq, .i_gates, .o_dev_dack_en, .o_irq, .o_irq_oe,
    .o_dma_request_pin, .o_dma_request_pin_oe
  );
  isa_host_model i_isa_host_model (
    .i_clk_sys, .i_irq(o_irq), .i_irq_oe(o_irq_oe), .i_drq(o_dma_request_pin),
    .i_drq_oe(o_dma_request_pin_oe), .o_irq_line(irq_line), .o_drq_line(drq_line),
    .o_irq_edges(irq_edges)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic put(input logic idx, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_cfg_wr <= 1'b1;
    i_cfg_is_index <= idx;
    i_cfg_wdata <= d;
  endtask : put
  task automatic cw(input logic [7:0] idx, input logic [7:0] d);
    put(1'b1, idx);
    put(1'b0, d);
    @(posedge i_clk_sys);
    i_cfg_wr <= 1'b0;
  endtask : cw
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    put(1'b1, idx);
    @(posedge i_clk_sys);
    i_cfg_wr <= 1'b0;
    i_cfg_is_index <= 1'b0;
    i_cfg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_cfg_rd <= 1'b0;
    #1;
    check(16'(o_cfg_rdata), 16'(exp));
  endtask : rd
  // Applies requests and gates, then waits out the one-cycle routing register
  task automatic drv(input logic [4:0] irq, input logic [4:0] drq);
    @(posedge i_clk_sys);
    i_dev_irq <= irq;
    i_dev_drq <= drq;
    i_gates <= g;
    @(posedge i_clk_sys);
    #1;
  endtask : drv
  task automatic io(input logic [15:0] a, input logic w);
    @(posedge i_clk_sys);
    i_io_addr <= a;
    i_io_rd <= ~w;
    i_io_wr <= w;
    #1;
  endtask : io
  task automatic dev(input logic [7:0] ldn, input logic [15:0] base);
    cw(IDX_LDN, ldn);
    cw(IDX_BASE0_HI, base[15:8]);
    cw(IDX_BASE0_LO, base[7:0]);
    cw(IDX_ACT, 8'h01);
  endtask : dev
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    cw(IDX_LDN, LDN_DISK);
    rd(IDX_IRQ_SEL, IRQ_SEL_RST);
    rd(IDX_DMA_SEL, DMA_SEL_RST);
    check(o_irq_oe, 16'h0000);
    check(16'(o_dma_request_pin_oe), 16'h0000);
    $display("test reset done");
    dev(LDN_DISK, 16'h00f8);
    io(16'h00fa, 1'b0);
    check(16'(o_dev_sel_rd), 16'h0000);
    cw(IDX_BASE0_LO, 8'hf0);
    cw(IDX_BASE0_HI, 8'h03);
    rd(IDX_BASE0_HI, 8'h03);
    io(16'hf3f2, 1'b1);
    check(16'(o_dev_sel_wr), 16'h0001);
    check(16'(o_dev_offset), 16'h0002);
    cw(IDX_IRQ_SEL, 8'h06);
    cw(IDX_DMA_SEL, 8'h02);
    drv(5'h01, 5'h01);
    check(o_irq_oe, 16'h0000);
    check(16'(o_dma_request_pin_oe), 16'h0000);
    g.disk_dma_irq_gate = 1'b1;
    drv(5'h01, 5'h01);
    check(o_irq_oe, 16'h0040);
    check(irq_line, 16'h0040);
    check(16'(drq_line), 16'h0004);
    check(16'(o_dev_dack_en), 16'h0001);
    drv(5'h00, 5'h00);
    check(16'(irq_edges), 16'h0001);
    for (int n = 0; n < 16; n++) begin
      cw(IDX_IRQ_SEL, 8'hf0 | 8'(n));
      rd(IDX_IRQ_SEL, 8'(n));
      drv(5'h01, 5'h00);
      check(o_irq_oe, (n == 0) ? 16'h0000 : 16'h0001 << n);
    end
    for (int s = 0; s < 8; s++) begin
      cw(IDX_DMA_SEL, 8'hf8 | 8'(s));
      rd(IDX_DMA_SEL, 8'(s));
      drv(5'h00, 5'h01);
      check(16'(o_dma_request_pin_oe), (s >= 1 && s <= 3) ? 16'h0001 << s : 16'h0000);
    end
    cw(IDX_IRQ_SEL, 8'h00);
    $display("test disk done");
    cw(IDX_LDN, LDN_KBD);
    cw(IDX_ACT, 8'h01);
    cw(IDX_BASE0_HI, 8'h02);
    rd(IDX_BASE0_HI, 8'h00);
    io(16'h0060, 1'b0);
    check(16'(o_dev_sel_rd), 16'h0010);
    io(16'h5064, 1'b0);
    check(16'(o_dev_offset), 16'h0004);
    $display("test keyboard done");
    dev(LDN_PRN, 16'h0378);
    g.ext_mode = EXT_MODE_EPP;
    drv(5'h00, 5'h00);
    io(16'h037b, 1'b0);
    check(16'(o_epp_addr_sel), 16'h0001);
    io(16'h037e, 1'b0);
    check(16'({o_epp_data_sel, o_epp_lane}), 16'h0006);
    for (int k = 0; k < 3; k++) begin
      io(16'h0778 + 16'(k), 1'b0);
      check(16'({o_ext_fifo_sel, o_ext_cfgb_sel, o_ext_ctrl_sel}), 16'h0004 >> k);
    end
    cw(IDX_BASE0_LO, 8'h7c);
    io(16'h037f, 1'b0);
    check(16'({o_dev_sel_rd, o_epp_addr_sel}), 16'h0004);
    cw(IDX_BASE0_LO, 8'h78);
    cw(IDX_IRQ_SEL, 8'h07);
    cw(IDX_DMA_SEL, 8'h03);
    drv(5'h02, 5'h02);
    check(o_irq_oe, 16'h0000);
    g.prn_irq_gate = 1'b1;
    drv(5'h02, 5'h02);
    check(o_irq_oe, 16'h0080);
    g.ext_mode = EXT_MODE_ECP;
    g.ext_service_intr = 1'b1;
    drv(5'h02, 5'h02);
    check(o_irq_oe, 16'h0000);
    check(16'(o_dma_request_pin_oe), 16'h0000);
    g.ext_service_intr = 1'b0;
    g.ext_dma_enable = 1'b1;
    drv(5'h02, 5'h02);
    check(o_irq_oe, 16'h0080);
    check(16'(o_dma_request_pin_oe), 16'h0008);
    g.ext_mode = EXT_MODE_FIFO;
    g.prn_irq_gate = 1'b0;
    drv(5'h02, 5'h02);
    check(o_irq_oe, 16'h0000);
    check(16'(o_dma_request_pin_oe), 16'h0008);
    $display("test printer done");
    dev(LDN_SER1, 16'h02f8);
    cw(IDX_IRQ_SEL, 8'h03);
    g.uart1_aux2 = 1'b1;
    drv(5'h04, 5'h00);
    check(16'(o_irq_oe[3]), 16'h0000);
    g.uart1_aux2 = 1'b0;
    g.uart1_int_enable = 4'h8;
    drv(5'h04, 5'h00);
    check(16'(o_irq_oe[3]), 16'h0000);
    g.uart1_aux2 = 1'b1;
    drv(5'h04, 5'h00);
    check(16'(irq_line[3]), 16'h0001);
    cw(IDX_LDN, LDN_SER2);
    cw(IDX_BASE1_HI, 8'h02);
    cw(IDX_BASE1_LO, 8'he8);
    cw(IDX_ACT, 8'h01);
    rd(IDX_BASE1_LO, 8'he8);
    io(16'h12ea, 1'b0);
    check(16'(o_dev_sel_rd), 16'h0008);
    check(16'(o_dev_offset), 16'h0002);
    $display("test serial done");
    conclude();
  end
endmodule : test_logical_device_resource_routing
